// ### src/motor_drive_pkg.sv
package motor_drive_pkg;
  // Motor indices inside the three-wide vectors
  localparam int MOTOR_COUNT = 3;
  localparam int IDX_MAIN = 0;
  localparam int IDX_TRANSPORT = 1;
  localparam int IDX_DEVELOPER = 2;
  // Register bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PERIOD_W = 16;
  // Register byte addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_REF_PERIOD0 = 8'h08;
  localparam logic [7:0] ADDR_DRIVE_PERIOD0 = 8'h14;
  localparam logic [7:0] ADDR_STRIDE = 8'h04;
  // Control field layout and reset values
  localparam int CTRL_TOL_LSB = 0;
  localparam int CTRL_TOL_W = 8;
  localparam int CTRL_DEV_POL_BIT = 8;
  localparam logic [7:0] TOL_RESET = 8'h04;
  localparam logic DEV_POL_RESET = 1'b0;
  // Status field layout
  localparam int STAT_LOCK_LSB = 0;
  localparam int STAT_RUN_LSB = 3;
  // Drive loop constants
  localparam logic [15:0] PERIOD_MAX = 16'hFFFF;
  localparam logic [15:0] STEP_HIGH = 16'h0010;
  localparam logic [15:0] STEP_LOW = 16'h0004;
  localparam logic [2:0] LOCK_EDGES = 3'h4;
endpackage

// ### src/motor_drive.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Main lock pin low locked, high unlocked
// - Drive speed follows reference clock frequency
// - Transport lock pin low locked, high unlocked
// - Developer lock pin low locked, high unlocked
module motor_drive (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Main drive pins
  input wire logic main_drive_run_n,
  input wire logic main_drive_brake_n,
  input wire logic main_drive_direction,
  input wire logic main_drive_speed_select,
  input wire logic main_drive_ref_clock,
  output logic main_drive_lock_n,
  // Transport drive pins
  input wire logic transport_drive_run_n,
  input wire logic transport_drive_direction,
  input wire logic transport_drive_speed_select,
  input wire logic transport_drive_ref_clock,
  output logic transport_drive_lock_n,
  // Developer drive pins
  input wire logic developer_drive_run,
  input wire logic developer_drive_direction,
  input wire logic developer_drive_ref_clock,
  output logic developer_drive_lock_n,
  // Commutation towards the three motor stages
  output logic [2:0] commutation_tick,
  output logic [2:0] rotate_ccw,
  // Register port
  input wire logic [motor_drive_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [motor_drive_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [motor_drive_pkg::DATA_W-1:0] reg_rdata
);
  import motor_drive_pkg::*;

  function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction

  logic [10:0] pin_meta_reg;
  logic [10:0] pin_sync_reg;
  logic [2:0] ref_prev_reg;
  logic [2:0] ref_edge;
  logic [2:0] run_ok;
  logic [2:0] fast_range;
  logic [2:0] ccw_req;
  logic [7:0] tol_reg;
  logic dev_pol_reg;
  logic [15:0] cnt_reg [3];
  logic [15:0] ref_period_reg [3];
  logic [15:0] drive_period_reg [3];
  logic [15:0] phase_reg [3];
  logic [2:0] lock_cnt_reg [3];
  logic [2:0] locked_reg;
  logic ref_main_meta_reg;
  logic ref_main_sync_reg;

  // Every pin is asynchronous to clk, so all pass two flops first
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_meta_reg <= 11'h6EF; // Idle levels; reference clocks low so no false edge follows reset
      pin_sync_reg <= 11'h6EF;
    end else begin
      pin_meta_reg <= {developer_drive_direction, developer_drive_run, developer_drive_ref_clock,
                       transport_drive_speed_select, transport_drive_direction, transport_drive_run_n,
                       transport_drive_ref_clock, main_drive_speed_select, main_drive_direction,
                       main_drive_brake_n, main_drive_run_n};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Decoded commands; braking counts as not running so the loop unlocks
  assign run_ok[IDX_MAIN] = !pin_sync_reg[0] && pin_sync_reg[1];
  assign run_ok[IDX_TRANSPORT] = !pin_sync_reg[5];
  // Developer run polarity is a software bit until confirmed on hardware
  assign run_ok[IDX_DEVELOPER] = (pin_sync_reg[9] == dev_pol_reg);
  assign ccw_req = {pin_sync_reg[10], pin_sync_reg[6], pin_sync_reg[2]};
  assign fast_range = {1'b1, pin_sync_reg[7], pin_sync_reg[3]};
  assign ref_edge = {pin_sync_reg[8], pin_sync_reg[4], ref_main_sync_reg} & ~ref_prev_reg;

  // Main reference clock gets its own synchroniser pair
  always_ff @(posedge clk) begin
    if (srst) begin
      ref_main_meta_reg <= 1'b0;
      ref_main_sync_reg <= 1'b0;
    end else begin
      ref_main_meta_reg <= main_drive_ref_clock;
      ref_main_sync_reg <= ref_main_meta_reg;
    end
  end

  // Edge history of the synchronised reference clocks
  always_ff @(posedge clk) begin
    if (srst) begin
      ref_prev_reg <= 3'h0;
    end else begin
      ref_prev_reg <= {pin_sync_reg[8], pin_sync_reg[4], ref_main_sync_reg};
    end
  end

  // Per-drive loop: measure reference period, slew drive period, judge lock
  always_ff @(posedge clk) begin
    for (int i = 0; i < MOTOR_COUNT; i++) begin
      if (srst) begin
        cnt_reg[i] <= 16'h0000;
        ref_period_reg[i] <= PERIOD_MAX;
        drive_period_reg[i] <= PERIOD_MAX;
        lock_cnt_reg[i] <= 3'h0;
        locked_reg[i] <= 1'b0;
      end else if (ref_edge[i]) begin
        cnt_reg[i] <= 16'h0001;
        ref_period_reg[i] <= cnt_reg[i];
        // Drive period walks toward the reference period, which sets speed
        if (!run_ok[i]) begin
          drive_period_reg[i] <= PERIOD_MAX;
        end else if (abs_diff(drive_period_reg[i], cnt_reg[i]) <= (fast_range[i] ? STEP_HIGH : STEP_LOW)) begin
          drive_period_reg[i] <= cnt_reg[i];
        end else if (drive_period_reg[i] > cnt_reg[i]) begin
          drive_period_reg[i] <= drive_period_reg[i] - (fast_range[i] ? STEP_HIGH : STEP_LOW);
        end else begin
          drive_period_reg[i] <= drive_period_reg[i] + (fast_range[i] ? STEP_HIGH : STEP_LOW);
        end
        // Lock needs several consecutive matching reference edges
        if (run_ok[i] && abs_diff(drive_period_reg[i], cnt_reg[i]) <= {8'h00, tol_reg}) begin
          if (lock_cnt_reg[i] != LOCK_EDGES) begin
            lock_cnt_reg[i] <= lock_cnt_reg[i] + 3'h1;
          end
          locked_reg[i] <= (lock_cnt_reg[i] + 3'h1 >= LOCK_EDGES);
        end else begin
          lock_cnt_reg[i] <= 3'h0;
          locked_reg[i] <= 1'b0;
        end
      end else if (!run_ok[i] || cnt_reg[i] == PERIOD_MAX) begin
        // Stopped drive or lost reference drops lock at once
        if (cnt_reg[i] != PERIOD_MAX) begin
          cnt_reg[i] <= cnt_reg[i] + 16'h0001;
        end
        if (!run_ok[i]) begin
          drive_period_reg[i] <= PERIOD_MAX;
        end
        lock_cnt_reg[i] <= 3'h0;
        locked_reg[i] <= 1'b0;
      end else begin
        cnt_reg[i] <= cnt_reg[i] + 16'h0001;
      end
    end
  end

  // Commutation tick every drive period while running
  always_ff @(posedge clk) begin
    for (int i = 0; i < MOTOR_COUNT; i++) begin
      if (srst || !run_ok[i]) begin
        phase_reg[i] <= 16'h0000;
        commutation_tick[i] <= 1'b0;
      end else if (phase_reg[i] + 16'h0001 >= drive_period_reg[i]) begin
        phase_reg[i] <= 16'h0000;
        commutation_tick[i] <= 1'b1;
      end else begin
        phase_reg[i] <= phase_reg[i] + 16'h0001;
        commutation_tick[i] <= 1'b0;
      end
    end
  end

  // Direction follows the pins; low means clockwise
  always_ff @(posedge clk) begin
    if (srst) begin
      rotate_ccw <= 3'h7;
    end else begin
      rotate_ccw <= ccw_req;
    end
  end

  // Lock pins are active low: low once locked, high otherwise
  assign main_drive_lock_n = !locked_reg[IDX_MAIN];
  assign transport_drive_lock_n = !locked_reg[IDX_TRANSPORT];
  assign developer_drive_lock_n = !locked_reg[IDX_DEVELOPER];

  // Control register writes
  always_ff @(posedge clk) begin
    if (srst) begin
      tol_reg <= TOL_RESET;
      dev_pol_reg <= DEV_POL_RESET;
    end else if (reg_write && reg_addr == ADDR_CONTROL) begin
      tol_reg <= reg_wdata[CTRL_TOL_LSB +: CTRL_TOL_W];
      dev_pol_reg <= reg_wdata[CTRL_DEV_POL_BIT];
    end
  end

  // Read data valid the cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      reg_rdata <= 32'h0000_0000;
      if (reg_addr == ADDR_CONTROL) begin
        reg_rdata[CTRL_TOL_LSB +: CTRL_TOL_W] <= tol_reg;
        reg_rdata[CTRL_DEV_POL_BIT] <= dev_pol_reg;
      end else if (reg_addr == ADDR_STATUS) begin
        reg_rdata[STAT_LOCK_LSB +: 3] <= locked_reg;
        reg_rdata[STAT_RUN_LSB +: 3] <= run_ok;
      end
      for (int i = 0; i < MOTOR_COUNT; i++) begin
        if (reg_addr == ADDR_REF_PERIOD0 + 8'(i) * ADDR_STRIDE) begin
          reg_rdata[PERIOD_W-1:0] <= ref_period_reg[i];
        end
        if (reg_addr == ADDR_DRIVE_PERIOD0 + 8'(i) * ADDR_STRIDE) begin
          reg_rdata[PERIOD_W-1:0] <= drive_period_reg[i];
        end
      end
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // A stopped drive never shows lock on the next cycle
  property p_main_stop_unlocks;
    @(posedge clk) disable iff (srst) !run_ok[IDX_MAIN] |=> main_drive_lock_n;
  endproperty
  a_main_stop_unlocks: assert property (p_main_stop_unlocks) else $error("main lock low while stopped");

  property p_transport_stop_unlocks;
    @(posedge clk) disable iff (srst) !run_ok[IDX_TRANSPORT] |=> transport_drive_lock_n;
  endproperty
  a_transport_stop_unlocks: assert property (p_transport_stop_unlocks) else $error("transport lock low while stopped");

  property p_dev_stop_unlocks;
    @(posedge clk) disable iff (srst) !run_ok[IDX_DEVELOPER] |=> developer_drive_lock_n;
  endproperty
  a_dev_stop_unlocks: assert property (p_dev_stop_unlocks) else $error("developer lock low while stopped");

  // Lock can only appear on a reference edge while running
  sequence s_main_edge_run;
    ref_edge[IDX_MAIN] && run_ok[IDX_MAIN];
  endsequence
  property p_main_lock_cause;
    @(posedge clk) disable iff (srst) $fell(main_drive_lock_n) |-> $past(ref_edge[IDX_MAIN] && run_ok[IDX_MAIN]);
  endproperty
  a_main_lock_cause: assert property (p_main_lock_cause) else $error("main lock without reference edge");

  // Lost reference clock drops lock
  property p_lost_ref_unlocks;
    @(posedge clk) disable iff (srst) (cnt_reg[IDX_TRANSPORT] == PERIOD_MAX) && !ref_edge[IDX_TRANSPORT] |=> transport_drive_lock_n;
  endproperty
  a_lost_ref_unlocks: assert property (p_lost_ref_unlocks) else $error("transport lock held without clock");

  // Matched period repeats the tick at exactly the drive period
  property p_tick_spacing;
    @(posedge clk) disable iff (srst) commutation_tick[IDX_DEVELOPER] && drive_period_reg[IDX_DEVELOPER] == 16'h0008
      && run_ok[IDX_DEVELOPER] ##1 (run_ok[IDX_DEVELOPER] && drive_period_reg[IDX_DEVELOPER] == 16'h0008) [*8]
      |-> commutation_tick[IDX_DEVELOPER];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("developer tick spacing wrong");
endmodule // motor_drive
`default_nettype wire

// ### tb/motor_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module motor_ctrl_model #(
  parameter int HALF = 4
) (
  // Clock and bench commands
  input wire logic clk,
  input wire logic [2:0] run_cmd,
  input wire logic brake_cmd,
  input wire logic main_ccw,
  input wire logic dev_run_level,
  // Pins towards the drives
  output logic main_drive_run_n,
  output logic main_drive_brake_n,
  output logic main_drive_direction,
  output logic main_drive_speed_select,
  output logic main_drive_ref_clock,
  output logic transport_drive_run_n,
  output logic transport_drive_direction,
  output logic transport_drive_speed_select,
  output logic transport_drive_ref_clock,
  output logic developer_drive_run,
  output logic developer_drive_direction,
  output logic developer_drive_ref_clock
);
  logic [7:0] div_reg = 8'h00;
  logic ref_reg = 1'b0;
  // Common divider; a stopped drive sees its clock parked low, not free running
  always_ff @(posedge clk) begin
    div_reg <= (div_reg == 8'(HALF - 1)) ? 8'h00 : div_reg + 8'h01;
    if (div_reg == 8'(HALF - 1)) begin
      ref_reg <= ~ref_reg;
    end
  end
  // One clock line per drive
  assign main_drive_ref_clock = ref_reg & run_cmd[0];
  assign transport_drive_ref_clock = ref_reg & run_cmd[1];
  assign developer_drive_ref_clock = ref_reg & run_cmd[2];
  // Control levels follow the commands right after the edge that set them
  assign main_drive_run_n = ~run_cmd[0];
  assign main_drive_brake_n = ~brake_cmd;
  assign main_drive_direction = main_ccw;
  assign main_drive_speed_select = 1'b1;
  assign transport_drive_run_n = ~run_cmd[1];
  assign transport_drive_direction = 1'b0;
  assign transport_drive_speed_select = 1'b1;
  // Run level is whichever polarity the bench says the drive expects
  assign developer_drive_run = run_cmd[2] ? dev_run_level : ~dev_run_level;
  assign developer_drive_direction = 1'b1;
endmodule // motor_ctrl_model
`default_nettype wire

// ### tb/pll_motor_control_signals_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pll_motor_control_signals_tb_top;
  import motor_drive_pkg::*;
  localparam int HALF = 4;
  localparam logic [31:0] PER = 32'(2 * HALF);
  logic clk = 1'b0, srst = 1'b1, brake_cmd = 1'b0, main_ccw = 1'b1, dev_run_level = 1'b0;
  logic reg_write = 1'b0, reg_read = 1'b0, rd_d = 1'b0;
  logic [2:0] run_cmd = 3'h0;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 32'h0, seed = 32'h0001_6EFA, exp_q[$];
  wire [DATA_W-1:0] reg_rdata;
  wire [2:0] commutation_tick, rotate_ccw;
  wire main_drive_run_n, main_drive_brake_n, main_drive_direction, main_drive_speed_select;
  wire main_drive_ref_clock, transport_drive_run_n, transport_drive_direction, transport_drive_speed_select;
  wire transport_drive_ref_clock, developer_drive_run, developer_drive_direction, developer_drive_ref_clock;
  wire main_drive_lock_n, transport_drive_lock_n, developer_drive_lock_n;
  wire [2:0] lock_n = {developer_drive_lock_n, transport_drive_lock_n, main_drive_lock_n};
  int n_fail = 0, total_checks = 0, cycles = 0, ticks[3] = '{0, 0, 0};
  // Clock, timeout and tick counting
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    for (int m = 0; m < 3; m++) if (commutation_tick[m] === 1'b1) ticks[m]++;
    if (cycles == 90000) begin
      n_fail++;
      end_sim();
    end
  end
  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rd_d <= reg_read;
    if (rd_d) check("reg_rdata", reg_rdata, exp_q.pop_front());
  end
  motor_ctrl_model #(.HALF(HALF)) i_motor_ctrl_model (.clk, .run_cmd, .brake_cmd, .main_ccw, .dev_run_level,
    .main_drive_run_n, .main_drive_brake_n, .main_drive_direction, .main_drive_speed_select, .main_drive_ref_clock,
    .transport_drive_run_n, .transport_drive_direction, .transport_drive_speed_select, .transport_drive_ref_clock,
    .developer_drive_run, .developer_drive_direction, .developer_drive_ref_clock);
  motor_drive i_motor_drive (.clk, .srst, .main_drive_run_n, .main_drive_brake_n, .main_drive_direction,
    .main_drive_speed_select, .main_drive_ref_clock, .main_drive_lock_n, .transport_drive_run_n,
    .transport_drive_direction, .transport_drive_speed_select, .transport_drive_ref_clock, .transport_drive_lock_n,
    .developer_drive_run, .developer_drive_direction, .developer_drive_ref_clock, .developer_drive_lock_n,
    .commutation_tick, .rotate_ccw, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bus cycles leave one idle cycle so no strobe is assigned twice in a step
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    if (!wr) exp_q.push_back(d);
    reg_addr <= a;
    reg_wdata <= wr ? d : 32'h0;
    reg_write <= wr;
    reg_read <= !wr;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    @(posedge clk);
  endtask
  // Bounded wait for the lock level of the selected drives
  task automatic wait_lock(input logic [2:0] sel);
    for (int i = 0; i < 40000 && (lock_n & sel) !== 3'h0; i++) @(negedge clk);
    @(posedge clk);
  endtask
  // Lock is sampled mid-cycle, then the next stimulus starts on a rising edge
  task automatic settle(output logic [2:0] l);
    repeat (8) @(posedge clk);
    @(negedge clk);
    l = lock_n;
    @(posedge clk);
  endtask
  task automatic end_sim();
    $display("Checks made %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    logic [2:0] l;
    logic d;
    int t0;
    repeat (8) @(negedge clk);
    check("lock_n reset", 32'(lock_n), 32'h7);
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    bus(1'b0, ADDR_CONTROL, {23'h0, DEV_POL_RESET, TOL_RESET});
    bus(1'b0, ADDR_REF_PERIOD0, 32'h0000FFFF);
    bus(1'b0, {3'b111, 5'(rnd() >> 27)}, 32'h0);
    $display("Test reset values done");
    // Dependent work starts once every drive reports lock or the 40000-cycle bounded wait runs out
    run_cmd <= 3'b111;
    wait_lock(3'b111);
    check("lock_n run", 32'(lock_n), 32'h0);
    bus(1'b0, ADDR_STATUS, 32'h0000003F);
    for (int m = 0; m < 3; m++) bus(1'b0, ADDR_REF_PERIOD0 + 8'(4 * m), PER);
    for (int m = 0; m < 3; m++) bus(1'b0, ADDR_DRIVE_PERIOD0 + 8'(4 * m), PER);
    bus(1'b1, ADDR_REF_PERIOD0, rnd());
    bus(1'b0, ADDR_REF_PERIOD0, PER);
    t0 = ticks[0];
    repeat (200) @(posedge clk);
    check("main ticks", 32'(ticks[0] - t0 >= 24 && ticks[0] - t0 <= 26), 32'h1);
    for (int k = 0; k < 4; k++) begin
      d = rnd() >> 31;
      main_ccw <= d;
      settle(l);
      check("rotate_ccw", 32'(rotate_ccw), {29'h0, 2'b10, d});
    end
    $display("Test lock and direction done");
    brake_cmd <= 1'b1;
    settle(l);
    check("brake lock_n", 32'(l), 32'h1);
    brake_cmd <= 1'b0;
    wait_lock(3'b001);
    run_cmd[0] <= 1'b0;
    settle(l);
    check("stop main lock_n", 32'(l), 32'h1);
    run_cmd[1] <= 1'b0;
    settle(l);
    t0 = ticks[1];
    repeat (50) @(posedge clk);
    check("stop transport", {28'h0, l, 32'(ticks[1] - t0) == 0}, 32'h7);
    $display("Test brake and stop done");
    bus(1'b1, ADDR_CONTROL, 32'h00000104);
    settle(l);
    check("developer polarity", 32'(l), 32'h7);
    bus(1'b0, ADDR_CONTROL, 32'h00000104);
    bus(1'b0, ADDR_STATUS, 32'h0);
    dev_run_level <= 1'b1;
    settle(l);
    bus(1'b0, ADDR_STATUS, 32'h00000020);
    $display("Test developer polarity done");
    // Let the last read answer be compared before the verdict
    repeat (2) @(posedge clk);
    check("pending reads", 32'(exp_q.size()), 32'h0);
    end_sim();
  end
endmodule // pll_motor_control_signals_tb_top
`default_nettype wire
